// ### rtl/per_cfg.svh
`ifndef PER_CFG_SVH
`define PER_CFG_SVH

// sizes
`define PER_NCH 8
`define PER_NSRC 16
`define PER_NUSR 8
`define PER_PRE_W 15
`define PER_USR_W 5

// register map (byte addresses, 32-bit words)
`define PER_SEL_BLK 3'b000
`define PER_USR_BLK 3'b010
`define PER_ADDR_VALUE 8'h20
`define PER_ADDR_TRIG 8'h24
`define PER_ADDR_SEEN 8'h28

// channel_source_select encoding
`define PER_SEL_NONE 8'h00
`define PER_SEL_SRC_HI 4'h1
`define PER_SEL_PCLK_HI 4'h8

// user config fields
`define PER_USR_EN_BIT 4
`define PER_USR_MODE_BIT 3

// reset values
`define PER_RST_BYTE 8'h00
`define PER_RST_USR 5'h00

`endif

// ### rtl/per_pkg.sv
`include "per_cfg.svh"

package per_pkg;

    typedef enum logic [1:0] {
        PER_KIND_NONE = 2'b00,
        PER_KIND_HW = 2'b01,
        PER_KIND_PCLK = 2'b10
    } per_kind_e;

    typedef enum logic {
        PER_MODE_SIG = 1'b0,
        PER_MODE_DATA = 1'b1
    } per_mode_e;

    typedef logic [7:0] per_sel_t;

    // what kind of source a select value names; anything else acts as none
    function automatic per_kind_e per_sel_kind(input per_sel_t s);
        if (s[7:4] == `PER_SEL_SRC_HI) begin
            return PER_KIND_HW;
        end else if (s[7:4] == `PER_SEL_PCLK_HI) begin
            return PER_KIND_PCLK;
        end
        return PER_KIND_NONE;
    endfunction : per_sel_kind

    // low-bit mask for a divide-by-2^e prescaler
    function automatic logic [`PER_PRE_W-1:0] per_div_mask(input logic [3:0] e);
        logic [15:0] f;
        f = 16'(16'h0001 << e) - 16'h0001;
        return f[`PER_PRE_W-1:0];
    endfunction : per_div_mask

endpackage : per_pkg

// ### rtl/per_prescaler.sv
`timescale 1ns/1ps
`include "per_cfg.svh"

module per_prescaler
    import per_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic [3:0] div_exp,
    output logic tick
);

    logic [`PER_PRE_W-1:0] cnt_r;
    logic [`PER_PRE_W-1:0] cnt_nxt;
    wire [`PER_PRE_W-1:0] mask = per_div_mask(div_exp);

    // tick when all counted low bits are ones: divide by 2^div_exp
    assign tick = &(cnt_r | ~mask);
    assign cnt_nxt = (restart | tick) ? '0 : cnt_r + {{(`PER_PRE_W-1){1'b0}}, 1'b1};

    // free running per channel, so each channel keeps its own phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : per_prescaler

// ### rtl/per_event_user.sv
`timescale 1ns/1ps
`include "per_cfg.svh"

module per_event_user
    import per_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`PER_USR_W-1:0] cfg,
    input wire logic [`PER_NCH-1:0] ch_stb,
    input wire logic [`PER_NCH-1:0] ch_dat,
    output logic trig,
    output logic [1:0] code
);

    logic trig_nxt;
    logic [1:0] code_nxt;
    wire en = cfg[`PER_USR_EN_BIT];
    wire data_mode = (cfg[`PER_USR_MODE_BIT] == PER_MODE_DATA);
    wire [2:0] ch = cfg[2:0];
    wire s = ch_stb[ch];
    wire d = ch_dat[ch];

    // signaling users see only the strobe and never the data bit
    assign code_nxt = (en & data_mode) ? {s, d} : 2'b00;
    assign trig_nxt = en & (data_mode ? (s | d) : s);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig <= 1'b0;
            code <= 2'b00;
        end else begin
            trig <= trig_nxt;
            code <= code_nxt;
        end
    end

endmodule : per_event_user

// ### rtl/per_event_router.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "per_cfg.svh"

// What this block does
// - eight independent channels, each a multiplexer from sources to users
// - generator to user action in at most two clock cycles
// - fully operating in active and idle sleep modes
// - signaling events and data events carrying extra information
// - any channel to any user; signaling users ignore data bits
// - data-capable users take signaling too; mode set per user
// - per-channel prescaler from divide-by-1 to divide-by-32768
// - prescalers independent per channel; one channel feeds many users
// - value written before trigger; only trigger write starts events
// - value and trigger hold one bit per channel, bit n channel n
// - one trigger write fires all its channels in the same cycle
// - software event lasts one cycle and overrides other sources
// - trigger/value 00 none, 01 data 01, 10 data 02, 11 data 03
// - channels usable as DMA transfer triggers
// - every channel event is a one-cycle pulse unless source says otherwise
// - select zero passes no source; software events still pass
module per_event_router
    import per_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`PER_NSRC-1:0] src_stb,
    input wire logic [`PER_NSRC-1:0] src_dat,
    output logic [`PER_NCH-1:0] evt_stb,
    output logic [`PER_NCH-1:0] evt_dat,
    output logic [`PER_NUSR-1:0] usr_trig,
    output logic [2*`PER_NUSR-1:0] usr_code
);

    localparam int NCH = `PER_NCH;
    localparam int NUSR = `PER_NUSR;

    logic [NCH-1:0][7:0] sel_r;
    logic [NUSR-1:0][`PER_USR_W-1:0] usr_cfg_r;
    logic [7:0] sw_event_value_r;
    logic [7:0] sw_event_trigger_r;
    logic [7:0] seen_r;
    logic [7:0] seen_nxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [NCH-1:0] evt_stb_r;
    logic [NCH-1:0] evt_dat_r;
    logic [NCH-1:0] stb_nxt;
    logic [NCH-1:0] dat_nxt;
    logic [NCH-1:0] sel_wr;
    logic [NUSR-1:0] usr_wr;

    // apb phases: one wait state, write lands where pready is sampled high
    wire apb_acc = psel & penable;
    wire apb_first = apb_acc & ~pready_r;
    wire apb_done = apb_acc & pready_r;
    wire wr_done = apb_done & pwrite;
    wire [2:0] word_idx = paddr[4:2];
    wire aligned = (paddr[1:0] == 2'b00);

    // address decode
    wire hit_sel = aligned & (paddr[7:5] == `PER_SEL_BLK);
    wire hit_usr = aligned & (paddr[7:5] == `PER_USR_BLK);
    wire hit_val = (paddr == `PER_ADDR_VALUE);
    wire hit_trig = (paddr == `PER_ADDR_TRIG);
    wire hit_seen = (paddr == `PER_ADDR_SEEN);
    wire hit_any = hit_sel | hit_usr | hit_val | hit_trig | hit_seen;
    wire val_wr = wr_done & hit_val;
    wire seen_wr = wr_done & hit_seen;
    wire sw_wr = wr_done & hit_trig;
    wire [7:0] sw_bits = pwdata[7:0];

    // read mux, upper bits read zero
    wire [31:0] rd_word =
        hit_sel ? {24'h000000, sel_r[word_idx]} :
        hit_usr ? {27'h0000000, usr_cfg_r[word_idx]} :
        hit_val ? {24'h000000, sw_event_value_r} :
        hit_trig ? {24'h000000, sw_event_trigger_r} :
        hit_seen ? {24'h000000, seen_r} : 32'h00000000;

    // per-word write strobes
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            sel_wr[i] = wr_done & hit_sel & (word_idx == 3'(i));
        end
        for (int i = 0; i < NUSR; i++) begin
            usr_wr[i] = wr_done & hit_usr & (word_idx == 3'(i));
        end
    end

    // channels: no clock gating here, so idle sleep keeps routing alive
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire [7:0] s = sel_r[c];
        wire per_kind_e kind = per_sel_kind(s);
        wire pre_tick;
        wire hw_stb;
        wire hw_dat;
        wire sw_hit;

        per_prescaler u_pre (
            .pclk(pclk),
            .presetn(presetn),
            .restart(sel_wr[c]),
            .div_exp(s[3:0]),
            .tick(pre_tick)
        );

        // reserved and zero selects both fall to no source
        assign hw_stb = (kind == PER_KIND_HW) ? src_stb[s[3:0]] :
            ((kind == PER_KIND_PCLK) & pre_tick);
        assign hw_dat = (kind == PER_KIND_HW) & src_dat[s[3:0]];
        // trigger bit n with value bit n makes the two-bit event code
        assign sw_hit = sw_wr & (sw_bits[c] | sw_event_value_r[c]);
        assign stb_nxt[c] = sw_hit ? sw_bits[c] : hw_stb;
        assign dat_nxt[c] = sw_hit ? sw_event_value_r[c] : hw_dat;
    end

    // activity flags: a new event beats a clear in the same cycle
    assign seen_nxt = (seen_r & ~(seen_wr ? pwdata[7:0] : 8'h00)) | stb_nxt | dat_nxt;

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= apb_first;
            pslverr_r <= apb_first & ~hit_any;
            prdata_r <= apb_first ? rd_word : 32'h00000000;
        end
    end

    // software visible registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= '0;
            usr_cfg_r <= '0;
            sw_event_value_r <= `PER_RST_BYTE;
            sw_event_trigger_r <= `PER_RST_BYTE;
            seen_r <= `PER_RST_BYTE;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (sel_wr[i]) begin
                    sel_r[i] <= pwdata[7:0];
                end
            end
            for (int i = 0; i < NUSR; i++) begin
                if (usr_wr[i]) begin
                    usr_cfg_r[i] <= pwdata[`PER_USR_W-1:0];
                end
            end
            if (val_wr) begin
                sw_event_value_r <= pwdata[7:0];
            end
            if (sw_wr) begin
                sw_event_trigger_r <= sw_bits;
            end
            seen_r <= seen_nxt;
        end
    end

    // channel outputs, one cycle after the source; also the dma triggers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stb_r <= '0;
            evt_dat_r <= '0;
        end else begin
            evt_stb_r <= stb_nxt;
            evt_dat_r <= dat_nxt;
        end
    end

    // users pick any channel; their flop is the second cycle of latency
    for (genvar u = 0; u < NUSR; u++) begin : g_usr
        per_event_user u_usr (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(usr_cfg_r[u]),
            .ch_stb(evt_stb_r),
            .ch_dat(evt_dat_r),
            .trig(usr_trig[u]),
            .code(usr_code[2*u+1:2*u])
        );
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign evt_stb = evt_stb_r;
    assign evt_dat = evt_dat_r;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire [7:0] sel_src0 = {`PER_SEL_SRC_HI, 4'h0};
    wire [7:0] sel_pdiv1 = {`PER_SEL_PCLK_HI, 4'h0};
    wire [7:0] sel_pdiv2 = {`PER_SEL_PCLK_HI, 4'h1};
    wire [4:0] usr_data_ch0 = 5'h18;
    wire sw_t3 = sw_bits[3];
    wire sw_v3 = sw_event_value_r[3];
    wire no_wr = ~wr_done;

    property p_src_lat;
        (sel_r[0] == sel_src0) && src_stb[0] && !sw_wr |=> evt_stb_r[0];
    endproperty
    a_src_lat: assert property (p_src_lat) else $error("source event late");

    property p_usr_lat;
        (usr_cfg_r[0] == usr_data_ch0) && evt_stb_r[0] |=> usr_trig[0] && usr_code[1];
    endproperty
    a_usr_lat: assert property (p_usr_lat) else $error("user action late");

    property p_end_to_end;
        (sel_r[0] == sel_src0) && (usr_cfg_r[0] == usr_data_ch0) && src_stb[0] && no_wr
            |-> ##2 usr_trig[0];
    endproperty
    a_end_to_end: assert property (p_end_to_end) else $error("two-cycle path broken");

    property p_sel_zero;
        (sel_r[1] == `PER_SEL_NONE) && !sw_wr |=> !evt_stb_r[1] && !evt_dat_r[1];
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("event passed zero select");

    property p_rsv;
        (sel_r[2] != `PER_SEL_NONE) && (per_sel_kind(sel_r[2]) == PER_KIND_NONE) && !sw_wr
            |=> !evt_stb_r[2] && !evt_dat_r[2];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved select passed event");

    property p_sw_code;
        sw_wr && (sw_t3 || sw_v3) |=> {evt_stb_r[3], evt_dat_r[3]} == {$past(sw_t3), $past(sw_v3)};
    endproperty
    a_sw_code: assert property (p_sw_code) else $error("wrong software event code");

    property p_sw_multi;
        sw_wr && (sw_bits == 8'hff) |=> (evt_stb_r == 8'hff);
    endproperty
    a_sw_multi: assert property (p_sw_multi) else $error("channels not fired together");

    property p_sw_one;
        sw_wr && (sel_r[4] == `PER_SEL_NONE) ##1 !sw_wr |=> !evt_stb_r[4] && !evt_dat_r[4];
    endproperty
    a_sw_one: assert property (p_sw_one) else $error("software event too long");

    property p_val_only;
        val_wr && (sel_r[5] == `PER_SEL_NONE) |=> !evt_stb_r[5] && !evt_dat_r[5];
    endproperty
    a_val_only: assert property (p_val_only) else $error("value write fired event");

    property p_pre_div1;
        (sel_r[6] == sel_pdiv1) && !sw_wr |=> evt_stb_r[6];
    endproperty
    a_pre_div1: assert property (p_pre_div1) else $error("divide-by-1 missed tick");

    property p_pre_div2;
        evt_stb_r[7] && (sel_r[7] == sel_pdiv2) && no_wr ##1 no_wr |-> !evt_stb_r[7];
    endproperty
    a_pre_div2: assert property (p_pre_div2) else $error("divide-by-2 ticked twice");

    property p_usr_sig;
        usr_cfg_r[1][`PER_USR_MODE_BIT] == PER_MODE_SIG |=> usr_code[3:2] == 2'b00;
    endproperty
    a_usr_sig: assert property (p_usr_sig) else $error("signaling user decoded data");

    property p_usr_data;
        (usr_cfg_r[2] == usr_data_ch0) && evt_dat_r[0] && !evt_stb_r[0]
            |=> usr_trig[2] && (usr_code[5:4] == 2'b01);
    endproperty
    a_usr_data: assert property (p_usr_data) else $error("data user missed data event");

    property p_apb_once;
        pready_r |=> !pready_r;
    endproperty
    a_apb_once: assert property (p_apb_once) else $error("pready held too long");

    c_sw_multi: cover property (sw_wr && (sw_bits == 8'hff));
    c_pre_tick: cover property ((sel_r[7] == sel_pdiv2) && evt_stb_r[7] ##2 evt_stb_r[7]);
    c_usr_data: cover property (usr_trig[2] && (usr_code[5:4] == 2'b01));
    c_slverr: cover property (pready_r && pslverr_r);

endmodule : per_event_router

// ### tb/per_src_model.sv
`timescale 1ns/1ps

// generator side: drives one source with a 2-bit code, as a pulse or a level
module per_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic hold,
    input wire logic [3:0] idx,
    input wire logic [1:0] code,
    output logic [15:0] src_stb,
    output logic [15:0] src_dat
);
    // one cycle per go, continuous while hold; unused sources stay low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_stb <= 16'h0000;
            src_dat <= 16'h0000;
        end else begin
            src_stb <= 16'h0000;
            src_dat <= 16'h0000;
            if (go || hold) begin
                src_stb[idx] <= code[1];
                src_dat[idx] <= code[0];
            end
        end
    end
endmodule : per_src_model

// ### tb/per_event_router_tb_top.sv
`timescale 1ns/1ps
`include "per_cfg.svh"

module per_event_router_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, go = 1'b0, hold = 1'b0, mon_on = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [1:0] code = 2'h0;
    logic [15:0] src_stb, src_dat, usr_code;
    logic [7:0] evt_stb, evt_dat, usr_trig;
    logic [4:0] ucfg [8];
    logic [47:0] notes [$];
    int n_fail = 0, cmp_count = 0, cyc = 0;

    always #10 pclk = ~pclk;
    // counted on the falling edge so both processes read one value per rising edge
    always @(negedge pclk) cyc <= cyc + 1;

    per_event_router u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_stb(src_stb), .src_dat(src_dat), .evt_stb(evt_stb),
        .evt_dat(evt_dat), .usr_trig(usr_trig), .usr_code(usr_code));
    per_src_model u_src (.pclk(pclk), .presetn(presetn), .go(go), .hold(hold), .idx(idx),
        .code(code), .src_stb(src_stb), .src_dat(src_dat));

    task chk(input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task wrap_up;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // one apb transfer; waits for pready under a bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(40'(n < 50), 40'h1);
        if (n >= 50) wrap_up();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(40'({q, e}), 40'({x, xe}));
    endtask : rdc

    // source pulse through the partner; note holds the generator cycle
    task fire(input logic [3:0] i, input logic [1:0] c, input logic [7:0] m);
        @(posedge pclk);
        go <= 1'b1;
        idx <= i;
        code <= c;
        if (c != 2'b00 && m != 8'h00) notes.push_back({32'(cyc + 1), c[1] ? m : 8'h00,
            c[0] ? m : 8'h00});
        @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : fire

    // user model from the config table kept by the bench
    function automatic logic [23:0] exp_usr(input logic [7:0] s, input logic [7:0] d);
        logic [15:0] c;
        logic [7:0] t;
        int ch;
        c = 16'h0000;
        t = 8'h00;
        for (int u = 0; u < 8; u++) begin
            ch = ucfg[u][2:0];
            if (ucfg[u][4] && ucfg[u][3]) begin
                c[2*u+:2] = {s[ch], d[ch]};
                t[u] = s[ch] | d[ch];
            end else if (ucfg[u][4]) begin
                t[u] = s[ch];
            end
        end
        return {c, t};
    endfunction : exp_usr

    // monitor: any channel event takes the oldest note; users looked at one cycle on
    initial begin : mon
        logic [47:0] nt;
        forever begin
            @(posedge pclk);
            if (mon_on && (evt_stb !== 8'h00 || evt_dat !== 8'h00)) begin
                nt = (notes.size() > 0) ? notes.pop_front() : 48'h0;
                chk(40'({evt_stb, evt_dat}), 40'(nt[15:0]));
                chk(40'((cyc - int'(nt[47:16])) inside {1, 2}), 40'h1);
                @(posedge pclk);
                chk(40'({usr_code, usr_trig}), 40'(exp_usr(nt[15:8], nt[7:0])));
            end
        end
    end

    initial begin
        repeat (95000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end

    initial begin
        logic [7:0] t, v;
        int s, ch, n;
        int ks [4] = '{0, 1, 4, 15};
        void'($urandom(67));
        // users: channel 7-u except users 0 and 2 on channel 0, even users data mode, last one disabled
        for (int u = 0; u < 8; u++) begin
            ucfg[u] = (u == 7) ? 5'h00 : (u == 0 || u == 2) ? 5'h18 : {1'b1, ~u[0], 3'(7 - u)};
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped hole and a misaligned address
        for (int a = 0; a < 'h60; a += 4) begin
            rdc(8'(a), 32'h0, a >= 'h2c && a < 'h40);
        end
        rdc(8'h02, 32'h0, 1'b1);
        for (int k = 0; k < 8; k++) begin
            v = 8'($urandom);
            wr(8'(4 * k), 32'(v));
            rdc(8'(4 * k), 32'(v), 1'b0);
            wr(8'(4 * k), 32'h0);
            wr(8'('h40 + 4 * k), 32'(v));
            rdc(8'('h40 + 4 * k), 32'(v[4:0]), 1'b0);
            wr(8'('h40 + 4 * k), 32'(ucfg[k]));
        end
        repeat (4) @(posedge pclk);
        mon_on <= 1'b1;
        // fixed masks give all four codes, then random masks
        t = 8'h0f;
        v = 8'h33;
        for (int r = 0; r < 6; r++) begin
            wr(`PER_ADDR_VALUE, 32'(v));
            wr(`PER_ADDR_TRIG, 32'(t));
            notes.push_back({32'(cyc), t, v});
            rdc(`PER_ADDR_TRIG, 32'(t), 1'b0);
            t = 8'($urandom);
            v = 8'($urandom) | 8'h01;
        end
        // one source on two channels, reserved select beside, unselected source
        for (int k = 0; k < 4; k++) begin
            s = $urandom % 16;
            ch = $urandom % 8;
            wr(8'(4 * ch), 32'('h10 + s));
            wr(8'(4 * ((ch + 1) % 8)), 32'('h10 + s));
            wr(8'(4 * ((ch + 2) % 8)), 32'h20);
            fire(4'(s), 2'(k), 8'((1 << ch) | (1 << ((ch + 1) % 8))));
            fire(4'(s + 1), 2'h3, 8'h00);
            for (int j = 0; j < 8; j++) begin
                wr(8'(4 * j), 32'h0);
            end
        end
        // software event replaces a continuous hardware event for one cycle
        mon_on <= 1'b0;
        wr(8'h00, 32'h10);
        hold <= 1'b1;
        idx <= 4'h0;
        code <= 2'b01;
        wr(`PER_ADDR_VALUE, 32'h0);
        wr(`PER_ADDR_TRIG, 32'h1);
        s = 0;
        ch = 0;
        repeat (6) begin
            @(posedge pclk);
            s += ({evt_stb[0], evt_dat[0]} === 2'b10);
            ch += ({evt_stb[0], evt_dat[0]} === 2'b01);
        end
        chk(40'(s), 40'h1);
        chk(40'(ch), 40'h5);
        hold <= 1'b0;
        wr(8'h00, 32'h0);
        // prescaler period, smallest to largest divide
        foreach (ks[j]) begin
            wr(8'h08, 32'('h80 + ks[j]));
            for (int p = 0; p < 2; p++) begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (evt_stb[2] !== 1'b1 && n < 70000);
            end
            chk(40'(n), 40'(1 << ks[j]));
            wr(8'h08, 32'h0);
        end
        chk(40'(notes.size()), 40'h0);
        wrap_up();
    end
endmodule : per_event_router_tb_top
